// file: core/timer_pwm_defines.svh
// Constants of the three-unit timer/PWM block: register map, field positions,
// select codes and counter limits. Included by the prescaler and unit design files.
//
// Behaviour
// - A unit runs in timer mode while its mode-select bit is zero.
// - A unit runs in PWM mode while its mode-select bit is one.
// - Prescaler divides the source; each prescaled tick advances the counter by one.
// - Counting clock is the master clock; unit 0 may select the external clock pin.
// - Counter clear forces the counter to zero; from clear bit and mask bit.
// - Run signal starts and stops counting; external run applies in timer mode only.
// - Mask bit at one holds its unit in reset whatever else is set.
// - Level capture: unit 0 counts while pin high, stores count when low.
// - Edge capture: count from first rising edge to the next one.
// - Timer output frequency is tick frequency divided by compare minus reload.
// - Waveform bit picks a 50% square wave or a one-tick pulse.
// - Prescaler divides master or unit 0 external clock by selected ratio.
// - PWM output high from cycle start, low from compare until next start.
// - PWM period is 255 minus reload; high time is compare minus reload.
// - Every counting cycle restarts with the counter loaded from reload.
// - PWM compare of 255 keeps the output high.
// - PWM compare of zero or below reload keeps the output low.
// - A new compare value takes effect only at the end of the cycle.
// - A new reload value takes effect at the next counter load; the timer square wave uses it at once.
// - Clearing the run bit in PWM mode freezes the output level.
// - Output pins float while the unit or the device is in reset.
// - True and inverted outputs drive pins only when their select bits are set.
// - Divider code 0 divides by one, each step doubles, code 16 by 65536.
// - Waveform bit zero selects the pulse, one selects the square wave.
// - Unit 0 clear source: 00 internal, 01 external, 10 either.
`ifndef TIMER_PWM_DEFINES_SVH
`define TIMER_PWM_DEFINES_SVH

// Register map, slot and word indices
`define ADDR_W          8
`define UNIT_COUNT      3
`define UNIT_SLOT_MAX   2'h2
`define GLOBAL_SLOT     2'h3
`define OFS_CTRL        2'h0
`define OFS_CMP         2'h1
`define OFS_RLD         2'h2
`define OFS_CNT         2'h3
`define OFS_EXT         2'h0
`define OFS_PIN         2'h1
`define OFS_STATUS      2'h2

// Unit control word fields
`define CTRL_CLEAR      0
`define CTRL_CLR_EDGE   1
`define CTRL_RUN        2
`define CTRL_CAP_EDGE   3
`define CTRL_MODE       7
`define CTRL_DIV_LO     8
`define CTRL_DIV_HI     12
`define CTRL_SHAPE      13

// External source word fields
`define EXT_CLR_LO      0
`define EXT_CLR_HI      1
`define EXT_RUN_LO      2
`define EXT_RUN_HI      3
`define EXT_CLK         4
`define EXT_MASK_LO     5
`define EXT_MASK_HI     7

// Pin select word fields
`define PIN_TRUE_LO     0
`define PIN_TRUE_HI     2
`define PIN_INV_LO      3
`define PIN_INV_HI      5

// Source select codes
`define SRC_INTERNAL    2'h0
`define SRC_EXTERNAL    2'h1
`define SRC_EITHER      2'h2

// Synchroniser lanes
`define PIN_CLK         0
`define PIN_RUN         1
`define PIN_CLR         2

// Counter limits and divider
`define CNT_ZERO        8'h00
`define CNT_ONE         8'h01
`define CNT_FULL        8'hFF
`define PWM_LAST        8'hFE
`define DIV_MAX         5'h10
`define DIV_ALL_ONES    16'hFFFF
`define DIV_ONE         16'h0001

`endif

// file: core/timer_pwm_pkg.sv
// Types shared by the timer/PWM block: unit configuration, unit counting
// state, capture state machine and prescaler state.
package timer_pwm_pkg;

  typedef enum logic [1:0] {EDGE_WAIT, EDGE_COUNT, EDGE_DONE} edge_state_e;

  typedef struct packed {
    logic       mode;
    logic       run_bit;
    logic       clear_bit;
    logic       shape;
    logic [4:0] div;
    logic [7:0] cmp;
    logic [7:0] rld;
  } unit_cfg_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cmp_act;
    logic       out;
  } unit_run_s;

  typedef struct packed {
    logic [15:0] count;
  } presc_state_s;

endpackage : timer_pwm_pkg

// file: core/tick_prescaler.sv
// Power-of-two prescaler: turns source edges into one-cycle counting ticks.
// Assumes src_edge is a one-cycle enable in the pclk domain.
`timescale 1ns/10ps
`include "timer_pwm_defines.svh"

module tick_prescaler (
  input  wire logic       pclk,           // Master clock
  input  wire logic       presetn,        // Async reset, active low
  input  wire logic       clear,          // Hold divider at zero
  input  wire logic       src_edge,       // One source period elapsed
  input  wire logic [4:0] divider_select, // Ratio code
  output logic            prescaled_tick  // One-cycle counting tick
);
  import timer_pwm_pkg::*;

  presc_state_s st;
  presc_state_s next_st;
  logic [4:0]   code;
  logic [15:0]  low_mask;

  always_comb begin
    code = (divider_select > `DIV_MAX) ? `DIV_MAX : divider_select;
    low_mask = 16'((17'(`DIV_ONE) << code) - 17'(`DIV_ONE));
  end

  assign prescaled_tick = src_edge && ((st.count & low_mask) == low_mask);

  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.count = 16'h0000;
    end else if (src_edge) begin
      next_st.count = st.count + `DIV_ONE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : tick_prescaler

// file: core/timer_pwm_unit.sv
// Three 8-bit timer/PWM units with prescalers, APB register slave,
// unit 0 external clock, run and clear pins, and driven output pins.
// Assumes APB3 master on pclk; external pins synchronous-safe via sync.
`timescale 1ns/10ps
`include "timer_pwm_defines.svh"

module timer_pwm_unit (
  input  wire logic        pclk,              // Master clock
  input  wire logic        presetn,           // Async reset, active low
  input  wire logic        psel,              // APB select
  input  wire logic        penable,           // APB access phase
  input  wire logic        pwrite,            // APB write
  input  wire logic [7:0]  paddr,             // APB byte address
  input  wire logic [31:0] pwdata,            // APB write data
  output logic [31:0]      prdata,            // APB read data
  output logic             pready,            // APB ready
  output logic             pslverr,           // APB unmapped access
  input  wire logic        ext_clock_pin,     // Unit 0 external clock
  input  wire logic        ext_run_pin,       // Unit 0 external run
  input  wire logic        ext_clear_pin,     // Unit 0 external clear
  output logic [2:0]       waveform_pin,      // Unit outputs
  output logic [2:0]       waveform_pin_oe_n, // Low while driven
  output logic [2:0]       inverted_pin,      // Inverted unit outputs
  output logic [2:0]       inverted_pin_oe_n  // Low while driven
);
  import timer_pwm_pkg::*;

  typedef struct packed {
    unit_cfg_s [2:0] cfg;
    unit_run_s [2:0] unit;
    logic [7:0]      cap;
    logic [1:0]      ext_clear_source_sel;
    logic [1:0]      ext_run_source_sel;
    logic            ext_clock_sel;
    logic [2:0]      clear_mask_bit;
    logic [2:0]      output_pin_select;
    logic [2:0]      inverted_pin_select;
    logic [2:0]      sync1;
    logic [2:0]      sync2;
    logic [2:0]      sync3;
    edge_state_e     est;
    logic [31:0]     rdata;
  } timer_state_s;

  timer_state_s st;
  timer_state_s next_st;

  logic [2:0] held;
  logic [2:0] counter_run;
  logic [2:0] prescaled_tick;
  logic [2:0] src_edge;
  logic       clk_rise;
  logic       run_rise;
  logic       run_fall;
  logic       clr_rise;
  logic       ext_run;
  logic       int_clear0;
  logic       level_capture;
  logic       ext_clear_raw;
  logic       clr_edge_mode;
  logic       cap_edge_mode;
  logic       clr_edge_q;
  logic       cap_edge_q;
  logic [13:0] cfg_bits0;
  logic       held0_src;
  logic [6:0] ext_flags;
  logic       clr_edge_bit;
  logic       cap_edge_bit;
  logic [1:0] edge_sel;
  logic [1:0] next_edge_sel;

  // Bus decode
  logic [1:0] slot;
  logic [1:0] word;
  logic       unit_hit;
  logic       glob_hit;
  logic       mapped;
  logic       setup;
  logic       wr_acc;

  assign slot     = paddr[5:4];
  assign word     = paddr[3:2];
  assign unit_hit = (paddr[7:6] == 2'h0) && (slot <= `UNIT_SLOT_MAX);
  assign glob_hit = (paddr[7:6] == 2'h0) && (slot == `GLOBAL_SLOT)
                    && (word <= `OFS_STATUS);
  assign mapped   = unit_hit || glob_hit;
  assign setup    = psel && !penable;
  assign wr_acc   = psel && penable && pwrite && mapped;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;
  assign prdata   = st.rdata;

  // Edge detection reads only the second and third stages
  assign clk_rise = st.sync2[`PIN_CLK] && !st.sync3[`PIN_CLK];
  assign run_rise = st.sync2[`PIN_RUN] && !st.sync3[`PIN_RUN];
  assign run_fall = !st.sync2[`PIN_RUN] && st.sync3[`PIN_RUN];
  assign clr_rise = st.sync2[`PIN_CLR] && !st.sync3[`PIN_CLR];

  // Unit 0 external clear: level is active high, edge gives one pulse
  assign int_clear0 = !st.cfg[0].clear_bit;

  always_comb begin
    clr_edge_mode = clr_edge_q;
    cap_edge_mode = cap_edge_q;
  end

  assign clr_edge_q    = cfg_bits0[`CTRL_CLR_EDGE];
  assign cap_edge_q    = cfg_bits0[`CTRL_CAP_EDGE];
  assign ext_clear_raw = clr_edge_mode ? clr_rise : st.sync2[`PIN_CLR];

  // Unit 0 external run: level follows the pin, edge follows the capture state
  assign ext_run = cap_edge_mode ? (st.est == EDGE_COUNT) : st.sync2[`PIN_RUN];
  assign level_capture = !st.cfg[0].mode && !cap_edge_mode
                         && (st.ext_run_source_sel != `SRC_INTERNAL);

  always_comb begin
    unique case (st.ext_clear_source_sel)
      `SRC_EXTERNAL: held0_src = ext_clear_raw;
      `SRC_EITHER:   held0_src = ext_clear_raw || int_clear0;
      default:       held0_src = int_clear0;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < `UNIT_COUNT; g++) begin : g_unit
      logic int_run;
      assign int_run = st.cfg[g].run_bit;

      if (g == 0) begin : g_first
        assign held[g]     = st.clear_mask_bit[g] || held0_src;
        assign src_edge[g] = st.ext_clock_sel ? clk_rise : 1'b1;
        always_comb begin
          if (st.cfg[g].mode) begin
            counter_run[g] = int_run;
          end else begin
            unique case (st.ext_run_source_sel)
              `SRC_EXTERNAL: counter_run[g] = ext_run;
              `SRC_EITHER:   counter_run[g] = ext_run || int_run;
              default:       counter_run[g] = int_run;
            endcase
          end
        end
      end else begin : g_other
        assign held[g]        = st.clear_mask_bit[g] || !st.cfg[g].clear_bit;
        assign src_edge[g]    = 1'b1;
        assign counter_run[g] = int_run;
      end

      tick_prescaler u_presc (
        .pclk           (pclk),
        .presetn        (presetn),
        .clear          (held[g]),
        .src_edge       (src_edge[g]),
        .divider_select (st.cfg[g].div),
        .prescaled_tick (prescaled_tick[g])
      );

      // Pins float while held or in device reset
      assign waveform_pin[g]      = st.unit[g].out;
      assign inverted_pin[g]      = !st.unit[g].out;
      assign waveform_pin_oe_n[g] = held[g] || !st.output_pin_select[g];
      assign inverted_pin_oe_n[g] = held[g] || !st.inverted_pin_select[g];
    end
  endgenerate

  assign cfg_bits0 = {st.cfg[0].shape, st.cfg[0].div, st.cfg[0].mode, ext_flags};

  assign ext_flags = {3'h0, cap_edge_bit, st.cfg[0].run_bit, clr_edge_bit,
                      st.cfg[0].clear_bit};

  // Unit 0 edge selects live beside the configuration struct
  assign clr_edge_bit = edge_sel[0];
  assign cap_edge_bit = edge_sel[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel <= 2'h0;
    end else begin
      edge_sel <= next_edge_sel;
    end
  end

  always_comb begin
    next_edge_sel = edge_sel;
    if (wr_acc && unit_hit && slot == 2'h0 && word == `OFS_CTRL) begin
      next_edge_sel = {pwdata[`CTRL_CAP_EDGE], pwdata[`CTRL_CLR_EDGE]};
    end
  end

  // Read data word for the addressed register
  function automatic logic [31:0] ctrl_word(input unit_cfg_s c, input logic [1:0] es);
    ctrl_word = 32'h0000_0000;
    ctrl_word[`CTRL_CLEAR]                  = c.clear_bit;
    ctrl_word[`CTRL_CLR_EDGE]               = es[0];
    ctrl_word[`CTRL_RUN]                    = c.run_bit;
    ctrl_word[`CTRL_CAP_EDGE]               = es[1];
    ctrl_word[`CTRL_MODE]                   = c.mode;
    ctrl_word[`CTRL_DIV_HI:`CTRL_DIV_LO]    = c.div;
    ctrl_word[`CTRL_SHAPE]                  = c.shape;
  endfunction : ctrl_word

  always_comb begin
    logic [7:0] new_cnt;
    logic [7:0] span;
    logic       end_cyc;
    logic [1:0] es;
    new_cnt = `CNT_ZERO;
    span    = `CNT_ZERO;
    end_cyc = 1'b0;
    es      = 2'h0;
    next_st = st;

    // Three-stage synchroniser for the unit 0 pins
    next_st.sync1 = {ext_clear_pin, ext_run_pin, ext_clock_pin};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    // Edge capture sequence of unit 0
    if (held[0]) begin
      next_st.est = EDGE_WAIT;
    end else if (run_rise && cap_edge_mode) begin
      unique case (st.est)
        EDGE_WAIT:  next_st.est = EDGE_COUNT;
        EDGE_COUNT: next_st.est = EDGE_DONE;
        EDGE_DONE:  next_st.est = EDGE_DONE;
        default:    next_st.est = EDGE_WAIT;
      endcase
    end

    // Level capture stores the count when the pin falls
    if (level_capture && run_fall) begin
      next_st.cap = st.unit[0].cnt;
    end

    for (int i = 0; i < `UNIT_COUNT; i++) begin
      if (held[i]) begin
        next_st.unit[i].cnt     = `CNT_ZERO;
        next_st.unit[i].out     = 1'b0;
        next_st.unit[i].cmp_act = st.cfg[i].cmp;
      end else if (counter_run[i] && prescaled_tick[i]) begin
        if (st.cfg[i].mode) begin
          end_cyc = (st.unit[i].cnt >= `PWM_LAST);
        end else begin
          end_cyc = (st.unit[i].cnt + `CNT_ONE == st.unit[i].cmp_act)
                    || (st.unit[i].cnt == `CNT_FULL);
        end
        if (end_cyc) begin
          new_cnt = st.cfg[i].rld;
          next_st.unit[i].cmp_act = st.cfg[i].cmp;
        end else begin
          new_cnt = st.unit[i].cnt + `CNT_ONE;
        end
        next_st.unit[i].cnt = new_cnt;
        if (st.cfg[i].mode) begin
          // High from start until the compare is reached
          next_st.unit[i].out = (new_cnt < next_st.unit[i].cmp_act);
        end else if (st.cfg[i].shape) begin
          span = next_st.unit[i].cmp_act - st.cfg[i].rld;
          next_st.unit[i].out = ((new_cnt - st.cfg[i].rld) < (span >> 1));
        end else begin
          next_st.unit[i].out = end_cyc;
        end
      end
    end

    // Register writes
    if (wr_acc && unit_hit) begin
      unique case (word)
        `OFS_CTRL: begin
          next_st.cfg[slot].clear_bit = pwdata[`CTRL_CLEAR];
          next_st.cfg[slot].run_bit   = pwdata[`CTRL_RUN];
          next_st.cfg[slot].mode      = pwdata[`CTRL_MODE];
          next_st.cfg[slot].div       = pwdata[`CTRL_DIV_HI:`CTRL_DIV_LO];
          next_st.cfg[slot].shape     = pwdata[`CTRL_SHAPE];
        end
        `OFS_CMP: next_st.cfg[slot].cmp = pwdata[7:0];
        `OFS_RLD: next_st.cfg[slot].rld = pwdata[7:0];
        `OFS_CNT: ;
      endcase
    end else if (wr_acc && glob_hit) begin
      if (word == `OFS_EXT) begin
        next_st.ext_clear_source_sel = pwdata[`EXT_CLR_HI:`EXT_CLR_LO];
        next_st.ext_run_source_sel   = pwdata[`EXT_RUN_HI:`EXT_RUN_LO];
        next_st.ext_clock_sel        = pwdata[`EXT_CLK];
        next_st.clear_mask_bit       = pwdata[`EXT_MASK_HI:`EXT_MASK_LO];
      end else if (word == `OFS_PIN) begin
        next_st.output_pin_select   = pwdata[`PIN_TRUE_HI:`PIN_TRUE_LO];
        next_st.inverted_pin_select = pwdata[`PIN_INV_HI:`PIN_INV_LO];
      end
    end

    // Read data is latched in the setup cycle
    if (setup && !pwrite) begin
      next_st.rdata = 32'h0000_0000;
      if (unit_hit) begin
        es = (slot == 2'h0) ? edge_sel : 2'h0;
        unique case (word)
          `OFS_CTRL: next_st.rdata = ctrl_word(st.cfg[slot], es);
          `OFS_CMP:  next_st.rdata[7:0] = st.cfg[slot].cmp;
          `OFS_RLD:  next_st.rdata[7:0] = st.cfg[slot].rld;
          `OFS_CNT:  next_st.rdata[7:0] = (slot == 2'h0 && level_capture)
                                          ? st.cap : st.unit[slot].cnt;
        endcase
      end else if (glob_hit) begin
        if (word == `OFS_EXT) begin
          next_st.rdata[`EXT_CLR_HI:`EXT_CLR_LO]   = st.ext_clear_source_sel;
          next_st.rdata[`EXT_RUN_HI:`EXT_RUN_LO]   = st.ext_run_source_sel;
          next_st.rdata[`EXT_CLK]                  = st.ext_clock_sel;
          next_st.rdata[`EXT_MASK_HI:`EXT_MASK_LO] = st.clear_mask_bit;
        end else if (word == `OFS_PIN) begin
          next_st.rdata[`PIN_TRUE_HI:`PIN_TRUE_LO] = st.output_pin_select;
          next_st.rdata[`PIN_INV_HI:`PIN_INV_LO]   = st.inverted_pin_select;
        end else begin
          next_st.rdata[2:0]  = {st.unit[2].out, st.unit[1].out, st.unit[0].out};
          next_st.rdata[5:3]  = counter_run;
          next_st.rdata[8:6]  = held;
          next_st.rdata[10:9] = st.est;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : timer_pwm_unit

// file: test/timer_pwm_sva.sv
// Checker for timer_pwm_unit: bus answer and error response, floating pins
// during reset, mask and clear, and the inverted pin relation.
// Assumes it is bound into every timer_pwm_unit instance.
`timescale 1ns/10ps
module timer_pwm_sva (
  input wire logic        pclk,              // Master clock
  input wire logic        presetn,           // Async reset, active low
  input wire logic        psel,              // APB select
  input wire logic        penable,           // APB access phase
  input wire logic        pwrite,            // APB write
  input wire logic [7:0]  paddr,             // APB byte address
  input wire logic [31:0] pwdata,            // APB write data
  input wire logic        pready,            // APB ready
  input wire logic        pslverr,           // APB error
  input wire logic [2:0]  waveform_pin,      // Unit outputs
  input wire logic [2:0]  waveform_pin_oe_n, // Low while driven
  input wire logic [2:0]  inverted_pin,      // Inverted outputs
  input wire logic [2:0]  inverted_pin_oe_n  // Low while driven
);
  logic acc;
  assign acc = psel && penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_READY: assert property (acc |-> pready)
    else $error("no ready in access phase");
  AST_UNMAPPED: assert property (acc && paddr >= 8'h3C |-> pslverr)
    else $error("unmapped access without error");
  AST_MAPPED: assert property (acc && paddr < 8'h3C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access with error");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  AST_INVERSE: assert property (inverted_pin == ~waveform_pin)
    else $error("inverted pin not the inverse");
  AST_RESET_FLOAT: assert property (disable iff (1'b0)
    !presetn && !$past(presetn) |-> &waveform_pin_oe_n && &inverted_pin_oe_n)
    else $error("pin driven during reset");
  AST_RELEASE_FLOAT: assert property ($rose(presetn) |-> &waveform_pin_oe_n)
    else $error("pin driven at reset release");
  AST_MASK_FLOAT: assert property (acc && pwrite && paddr == 8'h30 && pwdata[5]
    |=> waveform_pin_oe_n[0] && inverted_pin_oe_n[0])
    else $error("masked unit drives its pins");
  AST_CLEAR_FLOAT: assert property (acc && pwrite && paddr == 8'h10 && !pwdata[0]
    |=> waveform_pin_oe_n[1] [*2])
    else $error("cleared unit drives its pin");
endmodule : timer_pwm_sva

bind timer_pwm_unit timer_pwm_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .waveform_pin(waveform_pin), .waveform_pin_oe_n(waveform_pin_oe_n),
  .inverted_pin(inverted_pin), .inverted_pin_oe_n(inverted_pin_oe_n));

// file: test/ext_pin_model.sv
// Unit 0 external pins and pulled-down loads on the true output pins.
// Assumes its tasks are called from the pclk domain.
`timescale 1ns/10ps
module ext_pin_model (
  input  wire logic       pclk,              // Master clock
  input  wire logic       clk_run,           // Let the external clock run
  input  wire logic [2:0] waveform_pin,      // Unit outputs
  input  wire logic [2:0] waveform_pin_oe_n, // Low while driven
  output logic            ext_clock_pin,     // External count clock
  output logic            ext_run_pin,       // External run
  output logic            ext_clear_pin,     // External clear, unused
  output logic [2:0]      pad                // Level on the loaded pin
);
  logic ph;
  assign pad = waveform_pin & ~waveform_pin_oe_n; // pull-down when floating
  initial begin
    ph = 1'b0;
    ext_clock_pin = 1'b0;
    ext_run_pin = 1'b0;
    ext_clear_pin = 1'b0;
  end
  // Clock stands still outside frames, else a quarter of the master rate
  always @(posedge pclk) begin
    ph <= clk_run ? ~ph : 1'b0;
    if (clk_run && ph)
      ext_clock_pin <= ~ext_clock_pin;
  end
  task automatic pulses(input int n, input int h, input int l);
    repeat (n) begin
      @(posedge pclk);
      ext_run_pin <= 1'b1;
      repeat (h) @(posedge pclk);
      ext_run_pin <= 1'b0;
      repeat (l - 1) @(posedge pclk);
    end
  endtask : pulses
endmodule : ext_pin_model

// file: test/tb_top.sv
// Self-checking bench for timer_pwm_unit: APB tasks, waveform timing on
// the loaded pads, unit 0 external pins from ext_pin_model.
`timescale 1ns/10ps
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, clk_run, err, ck, rp, cr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr;
  logic [2:0]  wpin, woe, ipin, ioe, pad;
  logic [7:0]  cv[3] = '{8'hFF, 8'h00, 8'h32};
  int          tt[3][4] = '{'{16'h0205, 5, 4, 20}, '{16'h2005, 10, 5, 10}, '{16'h2105, 6, 6, 12}};
  int          ct[2][5] = '{'{16'h0001, 1, 40, 10, 40}, '{16'h0009, 2, 15, 15, 30}};
  int          n_mismatch, num_checks, hi, per, t0, k;
  int          cyc = 0;
  timer_pwm_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clock_pin(ck), .ext_run_pin(rp), .ext_clear_pin(cr),
    .waveform_pin(wpin), .waveform_pin_oe_n(woe), .inverted_pin(ipin),
    .inverted_pin_oe_n(ioe));
  ext_pin_model u_ext (.pclk(pclk), .clk_run(clk_run), .waveform_pin(wpin),
    .waveform_pin_oe_n(woe), .ext_clock_pin(ck), .ext_run_pin(rp), .ext_clear_pin(cr),
    .pad(pad));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wait_pad(input int i, input logic v);
    int n = 0;
    while (pad[i] !== v && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000) begin
      n_mismatch++;
      $display("[ERR] pad %0d expected %0b seen timeout", i, v);
    end
  endtask : wait_pad
  // One full high/low cycle after the current one
  task automatic measure(input int i);
    wait_pad(i, 1'b0);
    wait_pad(i, 1'b1);
    t0 = cyc;
    wait_pad(i, 1'b0);
    hi = cyc - t0;
    wait_pad(i, 1'b1);
    per = cyc - t0;
  endtask : measure
  task automatic hold(input int i, input logic v, input int n);
    int m = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pad[i] === v) m++;
    end
    chk("steady level", n, m);
  endtask : hold
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {psel, penable, pwrite, clk_run, presetn} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("oe after reset", 6'h3F, {woe, ioe});
    apb(8'h40, 1'b0, 32'h0000_0000);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h0000_0000, rd);
    for (int u = 0; u < 3; u++) begin
      apb(8'(u * 16), 1'b1, 32'h0000_0080);
      apb(8'(u * 16 + 4), 1'b1, 32'h0000_0064);
      apb(8'(u * 16 + 8), 1'b1, 32'h0000_0037);
    end
    apb(8'h34, 1'b1, 32'h0000_003F);
    apb(8'h30, 1'b1, 32'h0000_00E0);
    for (int u = 0; u < 3; u++) apb(8'(u * 16), 1'b1, 32'h0000_0085);
    apb(8'h30, 1'b1, 32'h0000_0000);
    @(posedge pclk);
    chk("pins selected", 6'h00, {woe, ioe});
    k = 0;
    repeat (400) begin
      @(posedge pclk);
      if (pad === 3'b000 || pad === 3'b111) k++;
    end
    chk("units in step", 400, k);
    measure(1);
    chk("pwm high", 45, hi);
    chk("pwm period", 200, per);
    wait_pad(1, 1'b0);
    wait_pad(1, 1'b1);
    t0 = cyc;
    apb(8'h14, 1'b1, 32'h0000_003C);
    wait_pad(1, 1'b0);
    chk("high before new compare", 45, cyc - t0);
    measure(1);
    chk("high after new compare", 5, hi);
    foreach (cv[j]) begin
      apb(8'h14, 1'b1, {24'h00_0000, cv[j]});
      repeat (210) @(posedge pclk);
      hold(1, cv[j] == 8'hFF, 300);
    end
    apb(8'h14, 1'b1, 32'h0000_0064);
    wait_pad(1, 1'b1);
    apb(8'h10, 1'b1, 32'h0000_0081);
    hold(1, 1'b1, 300);
    apb(8'h30, 1'b1, 32'h0000_0040);
    @(posedge pclk);
    chk("masked unit floats", 3'b110, {woe[1], ioe[1], pad[1]});
    apb(8'h28, 1'b1, 32'h0000_0000);
    foreach (tt[j]) begin
      apb(8'h24, 1'b1, tt[j][1]);
      apb(8'h20, 1'b1, tt[j][0]);
      measure(2);
      chk("timer high", tt[j][2], hi);
      chk("timer period", tt[j][3], per);
    end
    apb(8'h08, 1'b1, 32'h0000_0000);
    apb(8'h04, 1'b1, 32'h0000_0004);
    apb(8'h30, 1'b1, 32'h0000_0010);
    clk_run <= 1'b1;
    apb(8'h00, 1'b1, 32'h0000_0005);
    measure(0);
    chk("ext clock high", 4, hi);
    chk("ext clock period", 16, per);
    clk_run <= 1'b0;
    apb(8'h04, 1'b1, 32'h0000_00FF);
    apb(8'h30, 1'b1, 32'h0000_0004);
    foreach (ct[j]) begin
      apb(8'h00, 1'b1, 32'h0000_0000);
      apb(8'h00, 1'b1, ct[j][0]);
      u_ext.pulses(ct[j][1], ct[j][2], ct[j][3]);
      apb(8'h0C, 1'b0, 32'h0000_0000);
      chk("captured count", ct[j][4], rd);
    end
    print_verdict();
  end
endmodule : tb_top
